// *** hw/nvram_host_pkg.sv ***
package nvram_host_pkg;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int ROW_BYTE_W = 3;
  localparam int ROW_W = ADDR_W - ROW_BYTE_W;
  localparam int ROW_COUNT = 4096;
  localparam int CLK_PERIOD_NS = 10;
  // slow-supply band figures, the worst case
  localparam int T_CA_NS = 80;
  localparam int T_PC_NS = 65;
  localparam int T_AH_NS = 15;
  localparam int T_OE_NS = 15;
  localparam int T_DS_NS = 40;
  localparam int T_HZ_NS = 15;
  localparam int CA_CYC = (T_CA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PC_CYC = (T_PC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int AH_CYC = (T_AH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OE_CYC = (T_OE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DS_CYC = (T_DS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HZ_CYC = (T_HZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CA_CNT = CNT_W'(CA_CYC - 1);
  localparam logic [CNT_W-1:0] PC_CNT = CNT_W'(PC_CYC - 1);
  localparam logic [CNT_W-1:0] HZ_CNT = CNT_W'(HZ_CYC - 1);
  localparam logic [CNT_W-1:0] DS_CNT = CNT_W'(DS_CYC);
  localparam int WEAR_W = 16;
  localparam logic [WEAR_W-1:0] WEAR_ZERO = 16'h0000;
  localparam logic [WEAR_W-1:0] WEAR_ONE = 16'h0001;
  localparam logic [WEAR_W-1:0] WEAR_MAX = 16'hFFFF;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ACTIVE = 5'h02,
    ST_END = 5'h04,
    ST_PRECHARGE = 5'h08,
    ST_OFF = 5'h10
  } bus_state_t;
endpackage

// *** hw/row_wear_mem.sv ***
`timescale 1ns/1ps
module row_wear_mem
  import nvram_host_pkg::*;
(
  // clock
  input wire logic sys_clk_in,
  input wire logic clk_en_in,
  // access
  input wire logic [ROW_W-1:0] rd_row_in,
  input wire logic wr_en_in,
  input wire logic [ROW_W-1:0] wr_row_in,
  input wire logic [WEAR_W-1:0] wr_data_in,
  output logic [WEAR_W-1:0] rd_data_out
);
  logic [WEAR_W-1:0] mem_q [ROW_COUNT];

  always_ff @(posedge sys_clk_in) begin
    if (clk_en_in && wr_en_in) begin
      mem_q[wr_row_in] <= wr_data_in;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (clk_en_in) begin
      rd_data_out <= mem_q[rd_row_in];
    end
  end
endmodule

// *** hw/nvram_host.sv ***
// Behaviour
// R1 - each access costs one wear cycle to the whole 64-bit row holding its byte, tracked here.
// R2 - rows start on every 8-byte aligned address.
// R3 - frequent data should live in different rows; the wear counters show how spread it is.
// R4 - the memory latches the address at chip select falling, so the address may move after hold.
// R5 - every access opens with a fresh falling edge of chip select; it is never held low.
// R6 - chip select goes high after each access, giving the precharge interval.
// R7 - the memory never blocks accesses in range, so this side alone gates them on supply.
// R8 - chip select stays high whenever the supply is below its minimum; only a new access is gated on supply, one under way keeps it low.
// R9 - write strobe stays high while the supply is out of range; only a new write is gated on supply, one under way keeps it low.
// R10 - chip select stays high at least the precharge time between accesses.
// R11 - writes hold output drive high, so the memory never drives the data lines.
// R12 - read data are taken only after the output enable access time has passed.
// R13 - the address is 15 bits wide, covering 32768 bytes.
// R14 - address bits 14:3 name the row and bits 2:0 the byte in it.
`timescale 1ns/1ps
module nvram_host
  import nvram_host_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  // supply monitor, high while the supply is within range
  input wire logic supply_ok_in,
  // user request
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic [ADDR_W-1:0] req_addr_in,
  input wire logic [DATA_W-1:0] req_wdata_in,
  output logic req_ready_out,
  output logic rsp_valid_out,
  output logic [DATA_W-1:0] rsp_rdata_out,
  // row wear query
  input wire logic [ROW_W-1:0] wear_row_in,
  output logic [WEAR_W-1:0] wear_count_out,
  // memory pins
  output logic chip_select_n_out,
  output logic write_strobe_n_out,
  output logic output_drive_n_out,
  output logic [ADDR_W-1:0] address_out,
  output logic [DATA_W-1:0] data_lines_out,
  output logic data_lines_oe_out,
  input wire logic [DATA_W-1:0] data_lines_in
);
  bus_state_t state_q;
  logic [CNT_W-1:0] cnt_q;
  logic write_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] wdata_q;
  logic go;
  logic wear_wr;
  logic [ROW_W-1:0] wear_row_q;
  logic [WEAR_W-1:0] wear_rd;
  logic [WEAR_W-1:0] wear_inc;
  logic clr_busy_q;
  logic [ROW_W-1:0] clr_row_q;
  logic wear_we;
  logic [ROW_W-1:0] wear_wr_row;
  logic [WEAR_W-1:0] wear_wr_data;

  assign go = (state_q == ST_IDLE) && req_valid_in && supply_ok_in; // R7 R8
  assign req_ready_out = (state_q == ST_IDLE) && supply_ok_in;

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      state_q <= ST_OFF;
      cnt_q <= CNT_ZERO;
    end else if (clk_en_in) begin
      unique case (state_q)
        ST_OFF: begin
          if (supply_ok_in && !clr_busy_q) begin
            state_q <= ST_PRECHARGE; // R10
            cnt_q <= PC_CNT;
          end
        end
        ST_IDLE: begin
          if (!supply_ok_in) begin
            state_q <= ST_OFF; // R8
          end else if (go) begin
            state_q <= ST_ACTIVE; // R5
            cnt_q <= CA_CNT;
          end
        end
        ST_ACTIVE: begin
          if (cnt_q == CNT_ZERO) begin
            state_q <= ST_END;
            cnt_q <= HZ_CNT;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        ST_END: begin
          if (cnt_q == CNT_ZERO) begin
            state_q <= ST_PRECHARGE; // R6
            cnt_q <= PC_CNT;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        ST_PRECHARGE: begin
          if (cnt_q == CNT_ZERO) begin
            state_q <= supply_ok_in ? ST_IDLE : ST_OFF; // R10
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        default: begin
          state_q <= ST_OFF;
        end
      endcase
    end
  end

  // request capture; address and data stay put for the whole cycle, beyond hold
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      write_q <= 1'b0;
      addr_q <= '0;
      wdata_q <= '0;
    end else if (clk_en_in && go) begin
      write_q <= req_write_in;
      addr_q <= req_addr_in; // R4 R13
      wdata_q <= req_wdata_in;
    end
  end

  // pins; chip select is only low in the active phase
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      chip_select_n_out <= 1'b1;
      write_strobe_n_out <= 1'b1;
      output_drive_n_out <= 1'b1;
      address_out <= '0;
      data_lines_out <= '0;
      data_lines_oe_out <= 1'b1;
    end else if (clk_en_in) begin
      chip_select_n_out <= !((go) || (state_q == ST_ACTIVE && cnt_q != CNT_ZERO)); // R5 R6 R8
      // strobe falls with select; output drive stays high on writes
      write_strobe_n_out <= !((go && req_write_in) ||
                              (state_q == ST_ACTIVE && write_q && cnt_q != CNT_ZERO)); // R11 R9
      output_drive_n_out <= !((go && !req_write_in) ||
                              (state_q == ST_ACTIVE && !write_q && cnt_q != CNT_ZERO));
      if (go) begin
        address_out <= req_addr_in; // R4
        data_lines_out <= req_wdata_in;
        data_lines_oe_out <= !req_write_in; // R11
      end else if (state_q == ST_END && cnt_q == CNT_ZERO) begin
        data_lines_oe_out <= 1'b1;
      end
    end
  end

  // read data sampled on the last low cycle of chip select, past the access time
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      rsp_valid_out <= 1'b0;
      rsp_rdata_out <= '0;
    end else if (clk_en_in) begin
      rsp_valid_out <= (state_q == ST_ACTIVE) && (cnt_q == CNT_ZERO);
      if (state_q == ST_ACTIVE && cnt_q == CNT_ZERO && !write_q) begin
        rsp_rdata_out <= data_lines_in; // R12
      end
    end
  end

  // wear accounting: read row count at start, write back incremented one cycle later
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      wear_row_q <= '0;
    end else if (clk_en_in && go) begin
      wear_row_q <= req_addr_in[ADDR_W-1:ROW_BYTE_W]; // R14 R2
    end
  end

  // after reset every row counter is swept to zero before the first access
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      clr_busy_q <= 1'b1;
      clr_row_q <= '0;
    end else if (clk_en_in && clr_busy_q) begin
      clr_row_q <= clr_row_q + 12'h001; // R1
      if (&clr_row_q) begin
        clr_busy_q <= 1'b0;
      end
    end
  end

  assign wear_wr = (state_q == ST_ACTIVE) && (cnt_q == CA_CNT); // R1
  assign wear_inc = (wear_rd == WEAR_MAX) ? WEAR_MAX : wear_rd + WEAR_ONE; // R1 R3
  assign wear_we = !reset_in && (clr_busy_q || wear_wr);
  assign wear_wr_row = clr_busy_q ? clr_row_q : wear_row_q;
  assign wear_wr_data = clr_busy_q ? WEAR_ZERO : wear_inc;

  row_wear_mem u_wear (
    .sys_clk_in(sys_clk_in),
    .clk_en_in(clk_en_in),
    .rd_row_in(state_q == ST_IDLE ? req_addr_in[ADDR_W-1:ROW_BYTE_W] :
               (state_q == ST_ACTIVE ? wear_row_q : wear_row_in)),
    .wr_en_in(wear_we),
    .wr_row_in(wear_wr_row),
    .wr_data_in(wear_wr_data),
    .rd_data_out(wear_rd)
  );
  assign wear_count_out = wear_rd;

  // assertions
  sequence select_fall_s;
    !$past(chip_select_n_out) == 1'b0 ##0 !chip_select_n_out;
  endsequence
  sequence precharge_s;
    chip_select_n_out [*7];
  endsequence

  cs_low_bound_a: assert property (@(posedge sys_clk_in) disable iff (reset_in || !clk_en_in)
    select_fall_s |-> !chip_select_n_out [*8] ##1 chip_select_n_out) // R5 R6
    else $error("select low phase wrong length");
  precharge_min_a: assert property (@(posedge sys_clk_in) disable iff (reset_in || !clk_en_in)
    $rose(chip_select_n_out) |-> precharge_s) // R10
    else $error("precharge too short");
  supply_gate_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    $fell(chip_select_n_out) |-> $past(supply_ok_in)) // R8 R7
    else $error("access started without supply");
  strobe_first_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    $fell(chip_select_n_out) && !write_strobe_n_out |-> !$past(write_strobe_n_out, 1)
    || $fell(write_strobe_n_out)) // R11
    else $error("write strobe late");
  strobe_idle_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    chip_select_n_out && $past(chip_select_n_out) |-> write_strobe_n_out) // R9
    else $error("write strobe low outside access");
  rw_exclusive_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    !(!write_strobe_n_out && !output_drive_n_out)) // R11
    else $error("strobe and output drive both low");
  addr_stable_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    !chip_select_n_out && !$fell(chip_select_n_out) |-> $stable(address_out)) // R4
    else $error("address moved during access");
  read_done_a: assert property (@(posedge sys_clk_in) disable iff (reset_in || !clk_en_in)
    $fell(chip_select_n_out) && output_drive_n_out == 1'b0 |-> ##8 rsp_valid_out) // R12
    else $error("read response timing");
  clear_idle_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    clr_busy_q |-> chip_select_n_out) // R1
    else $error("access started while wear counters clear");
endmodule

// *** verification/fram_model.sv ***
`timescale 1ns/1ps
module fram_model
  import nvram_host_pkg::*;
(
  // memory pins
  input wire logic chip_select_n_in,
  input wire logic write_strobe_n_in,
  input wire logic output_drive_n_in,
  input wire logic [ADDR_W-1:0] address_in,
  input wire logic [DATA_W-1:0] bus_in,
  input wire logic host_drive_n_in,
  input wire logic supply_ok_in,
  // device side of the data lines
  output logic [DATA_W-1:0] data_out,
  output int errs_out
);
  logic [DATA_W-1:0] mem [2**ADDR_W];
  int wear [ROW_COUNT];
  logic [ADDR_W-1:0] addr_q = '0;
  logic wr_q = 1'b0;
  logic ready_q = 1'b0;
  logic done_q = 1'b1;
  logic [DATA_W-1:0] last_q = 8'h00;
  realtime rise_t = -1000.0;
  logic drive;
  initial errs_out = 0;
  task automatic flag(input string what);
    errs_out++;
    $display("unexpected %s expected 0 seen 1", what);
  endtask
  // no supply lockout: accesses start at any level
  always @(negedge chip_select_n_in) begin
    // strobe and address change on the same host edge; let them settle first
    #0;
    if ($realtime - rise_t < T_PC_NS) flag("precharge_short");
    if (!supply_ok_in) flag("select_low_supply");
    addr_q = address_in;
    wr_q = !write_strobe_n_in;
    wear[address_in[ADDR_W-1:ROW_BYTE_W]]++;
    ready_q = 1'b0;
    done_q = 1'b0;
    #(T_CA_NS - 1) ready_q = !chip_select_n_in;
  end
  always @(posedge chip_select_n_in) begin
    rise_t = $realtime;
    if (wr_q && !done_q) mem[addr_q] = bus_in;
    done_q = 1'b1;
    ready_q = 1'b0;
  end
  always @(posedge write_strobe_n_in) begin
    if (!chip_select_n_in && wr_q && !done_q) begin
      mem[addr_q] = bus_in;
      done_q = 1'b1;
    end
  end
  always @(write_strobe_n_in, chip_select_n_in, supply_ok_in) begin
    if (!supply_ok_in && !write_strobe_n_in && !chip_select_n_in) flag("write_in_ramp");
  end
  assign drive = !chip_select_n_in && !output_drive_n_in && !wr_q && ready_q;
  always @(posedge drive) if (!host_drive_n_in) flag("bus_contention");
  always @(negedge drive) last_q = mem[addr_q];
  // a released bus shows the inverse of the last value rather than holding it
  assign data_out = drive ? mem[addr_q] : ~last_q;
endmodule

// *** verification/nvram_host_tb.sv ***
`timescale 1ns/1ps
module nvram_host_tb;
  import nvram_host_pkg::*;
  typedef struct packed {logic w; logic [ADDR_W-1:0] a; logic [DATA_W-1:0] d;} row_t;
  logic sys_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic clk_en_in = 1'b1;
  logic supply_ok_in = 1'b1;
  logic req_valid_in = 1'b0;
  logic req_write_in = 1'b0;
  logic [ADDR_W-1:0] req_addr_in = '0;
  logic [DATA_W-1:0] req_wdata_in = 8'h00;
  logic [ROW_W-1:0] wear_row_in = '0;
  logic req_ready_out, rsp_valid_out, chip_select_n_out, write_strobe_n_out;
  logic output_drive_n_out, data_lines_oe_out;
  logic [DATA_W-1:0] rsp_rdata_out, data_lines_out, data_lines_in, dev_data;
  logic [WEAR_W-1:0] wear_count_out;
  logic [ADDR_W-1:0] address_out;
  int n_fail = 0;
  int total_checks = 0;
  int mdl_errs;
  logic [DATA_W-1:0] mem_exp [int];
  int wear_exp [int];
  row_t rows [8] = '{{1'b1, 15'h0000, 8'hA5}, {1'b1, 15'h0007, 8'h3C}, {1'b1, 15'h0008, 8'hC3},
    {1'b1, 15'h7FFF, 8'h5A}, {1'b0, 15'h0000, 8'h00}, {1'b0, 15'h0007, 8'h00},
    {1'b0, 15'h0008, 8'h00}, {1'b0, 15'h7FFF, 8'h00}};
  always #5 sys_clk_in = ~sys_clk_in;
  assign data_lines_in = !data_lines_oe_out ? data_lines_out : dev_data;
  nvram_host nvram_host_i (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .clk_en_in(clk_en_in),
    .supply_ok_in(supply_ok_in), .req_valid_in(req_valid_in), .req_write_in(req_write_in),
    .req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in), .req_ready_out(req_ready_out),
    .rsp_valid_out(rsp_valid_out), .rsp_rdata_out(rsp_rdata_out), .wear_row_in(wear_row_in),
    .wear_count_out(wear_count_out), .chip_select_n_out(chip_select_n_out),
    .write_strobe_n_out(write_strobe_n_out), .output_drive_n_out(output_drive_n_out),
    .address_out(address_out), .data_lines_out(data_lines_out),
    .data_lines_oe_out(data_lines_oe_out), .data_lines_in(data_lines_in));
  fram_model fram_model_i (.chip_select_n_in(chip_select_n_out),
    .write_strobe_n_in(write_strobe_n_out), .output_drive_n_in(output_drive_n_out),
    .address_in(address_out), .bus_in(data_lines_in), .host_drive_n_in(data_lines_oe_out),
    .supply_ok_in(supply_ok_in), .data_out(dev_data), .errs_out(mdl_errs));
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic take(input row_t r);
    int n;
    n = 0;
    req_valid_in = 1'b1;
    req_write_in = r.w;
    req_addr_in = r.a;
    req_wdata_in = r.d;
    while (req_ready_out !== 1'b1 && n < 5000) begin
      @(negedge sys_clk_in);
      n++;
    end
    check("ready_wait", 16'h0001, {15'h0000, req_ready_out});
    @(negedge sys_clk_in);
    req_valid_in = 1'b0;
    wear_exp[r.a >> 3]++;
    if (r.w) mem_exp[r.a] = r.d;
  endtask
  task automatic access(input row_t r);
    int k;
    take(r);
    for (k = 1; k <= 10; k++) begin
      check("rsp_valid", {15'h0000, k == 9}, {15'h0000, rsp_valid_out});
      if (k < 10) @(negedge sys_clk_in);
    end
    if (!r.w) check("rdata", {8'h00, mem_exp[r.a]}, {8'h00, rsp_rdata_out});
  endtask
  task automatic gated_scan();
    // supply out of range: nothing may start
    supply_ok_in = 1'b0;
    req_valid_in = 1'b1;
    repeat (20) begin
      @(negedge sys_clk_in);
      check("gated_pins", 16'h0006, {13'h0000, chip_select_n_out, write_strobe_n_out,
        req_ready_out});
    end
    foreach (rows[i]) begin
      wear_row_in = rows[i].a[ADDR_W-1:ROW_BYTE_W];
      repeat (2) @(negedge sys_clk_in);
      check("wear_count", WEAR_W'(wear_exp[rows[i].a >> 3]), wear_count_out);
    end
    req_valid_in = 1'b0;
    supply_ok_in = 1'b1;
  endtask
  task automatic end_sim();
    n_fail += mdl_errs;
    if (n_fail == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #150000;
    n_fail++;
    end_sim();
  end
  initial begin
    repeat (16) @(negedge sys_clk_in);
    reset_in = 1'b0;
    foreach (rows[i]) access(rows[i]);
    // clock enable low mid-read: everything holds, then the access resumes
    take(rows[4]);
    clk_en_in = 1'b0;
    repeat (12) @(negedge sys_clk_in);
    check("frozen_pins", 16'h0000, {14'h0000, chip_select_n_out, rsp_valid_out});
    clk_en_in = 1'b1;
    repeat (8) @(negedge sys_clk_in);
    check("frozen_rsp", 16'h0001, {15'h0000, rsp_valid_out});
    check("frozen_rdata", {8'h00, mem_exp[rows[4].a]}, {8'h00, rsp_rdata_out});
    gated_scan();
    // reset while a read is under way
    take(rows[6]);
    repeat (3) @(negedge sys_clk_in);
    reset_in = 1'b1;
    repeat (2) @(negedge sys_clk_in);
    check("strobes_in_reset", 16'h000F, {12'h000, chip_select_n_out, write_strobe_n_out,
      output_drive_n_out, data_lines_oe_out});
    check("rsp_in_reset", 16'h0000, {15'h0000, rsp_valid_out});
    reset_in = 1'b0;
    // the release sweeps every row counter back to zero
    foreach (rows[i]) wear_exp[rows[i].a >> 3] = 0;
    access(rows[6]);
    gated_scan();
    end_sim();
  end
endmodule
